// File: design/pfh_map.svh
`ifndef PFH_MAP_SVH
`define PFH_MAP_SVH

// ****************************************
// bus geometry
// ****************************************
`define PFH_ADDR_W        19
`define PFH_DATA_W        8
`define PFH_SECT_LSB      16

// ****************************************
// timing in ns and derived cycle counts at 100 MHz
// ****************************************
`define PFH_CLK_NS        10
`define PFH_ACC_NS        70
`define PFH_WP_NS         35
`define PFH_WPH_NS        30
`define PFH_ACC_CYC       ((`PFH_ACC_NS + `PFH_CLK_NS - 1) / `PFH_CLK_NS)
`define PFH_WP_CYC        ((`PFH_WP_NS + `PFH_CLK_NS - 1) / `PFH_CLK_NS)
`define PFH_WPH_CYC       ((`PFH_WPH_NS + `PFH_CLK_NS - 1) / `PFH_CLK_NS)

// ****************************************
// unlock addresses and command data
// ****************************************
`define PFH_UNLK_A1       19'h00555
`define PFH_UNLK_A2       19'h002aa
`define PFH_UNLK_D1       8'haa
`define PFH_UNLK_D2       8'h55
`define PFH_CMD_PROG      8'ha0
`define PFH_CMD_ERASE     8'h80
`define PFH_CMD_CHIP      8'h10
`define PFH_CMD_SECT      8'h30
`define PFH_CMD_ID        8'h90
`define PFH_CMD_BYP       8'h20
`define PFH_CMD_BYP_RST   8'h00
`define PFH_CMD_RESET     8'hf0

`endif

// File: design/pfh_pkg.sv
package pfh_pkg;
  // host request kinds
  typedef enum logic [3:0] {
    PFH_OP_READ, PFH_OP_RESET, PFH_OP_PROG, PFH_OP_SECT_ERASE, PFH_OP_CHIP_ERASE,
    PFH_OP_ID_ENTER, PFH_OP_BYP_ENTER, PFH_OP_BYP_PROG, PFH_OP_BYP_EXIT
  } pfh_op_e;

  // one request from the user side
  typedef struct packed {
    pfh_op_e     op;
    logic [18:0] addr;
    logic [7:0]  data;
  } pfh_req_s;

  // one bus cycle handed to the cycle engine
  typedef struct packed {
    logic        wr;
    logic [18:0] addr;
    logic [7:0]  data;
  } pfh_cyc_s;
endpackage

// File: design/pfh_cycle.sv
`timescale 1ns/1ps
`include "pfh_map.svh"

// ****************************************
// single read or write cycle on the flash pins
// ****************************************
module pfh_cycle
  import pfh_pkg::*;
#(
  parameter int ACC_CYC = `PFH_ACC_CYC,
  parameter int WP_CYC  = `PFH_WP_CYC,
  parameter int WPH_CYC = `PFH_WPH_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // cycle request
  input  wire pfh_cyc_s    cyc,
  input  wire logic        cyc_valid,
  output logic             cyc_ready,
  output logic             cyc_done,
  output logic [7:0]       rd_data,
  // flash pins
  output logic [18:0]      byte_address_bus,
  output logic             chip_sel_n,
  output logic             out_en_n,
  output logic             wr_en_n,
  input  wire logic [7:0]  data_bus_i,
  output logic [7:0]       data_bus_o,
  output logic             data_bus_oe
);
  typedef enum logic [1:0] {PFC_IDLE, PFC_ACT, PFC_HOLD} pfc_state_e;

  pfc_state_e  st_q, st_d;      // cycle phase
  logic [7:0]  cnt_q, cnt_d;    // phase counter
  pfh_cyc_s    cur_q, cur_d;    // latched cycle
  logic [7:0]  rd_q, rd_d;      // captured read byte
  logic        done_q, done_d;  // one-cycle completion

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    cur_d  = cur_q;
    rd_d   = rd_q;
    done_d = 1'b0;
    unique case (st_q)
      PFC_IDLE: begin
        if (cyc_valid) begin
          cur_d = cyc;
          st_d  = PFC_ACT;
          // reads wait the full access time from select, covering standby exit
          cnt_d = cyc.wr ? 8'(WP_CYC) : 8'(ACC_CYC);
        end
      end
      PFC_ACT: begin
        if (cnt_q > 8'h01) begin
          cnt_d = cnt_q - 8'h01;
        end else begin
          if (!cur_q.wr) rd_d = data_bus_i;  // sample after access time
          st_d  = PFC_HOLD;
          cnt_d = 8'(WPH_CYC);
        end
      end
      PFC_HOLD: begin
        // strobes high; gives write pulse high time and bus turnaround
        if (cnt_q > 8'h01) begin
          cnt_d = cnt_q - 8'h01;
        end else begin
          st_d   = PFC_IDLE;
          done_d = 1'b1;
        end
      end
    endcase
  end

  // ****************************************
  // state registers
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q   <= PFC_IDLE;
      cnt_q  <= 8'h00;
      cur_q  <= '0;
      rd_q   <= 8'h00;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      cur_q  <= cur_d;
      rd_q   <= rd_d;
      done_q <= done_d;
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  assign cyc_ready        = (st_q == PFC_IDLE);
  assign cyc_done         = done_q;
  assign rd_data          = rd_q;
  assign byte_address_bus = cur_q.addr;
  // chip select only during a cycle; standby otherwise
  assign chip_sel_n       = (st_q == PFC_IDLE);
  assign out_en_n         = !((st_q == PFC_ACT) && !cur_q.wr);
  assign wr_en_n          = !((st_q == PFC_ACT) && cur_q.wr);
  // write data stays on through hold so data is valid at the rising strobe
  assign data_bus_oe      = (st_q != PFC_IDLE) && cur_q.wr;
  assign data_bus_o       = cur_q.data;
endmodule

// File: design/pfh_host.sv
// ****************************************
// ****************************************
`timescale 1ns/1ps
`include "pfh_map.svh"

module pfh_host
  import pfh_pkg::*;
#(
  parameter int ADDR_W = `PFH_ADDR_W,
  parameter int DATA_W = `PFH_DATA_W
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              arst_n,
  // user request
  input  wire pfh_req_s          req,
  input  wire logic              req_valid,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data,
  // mode view kept by the host
  output logic                   id_mode,
  output logic                   byp_mode,
  // flash pins
  output logic [ADDR_W-1:0]      byte_address_bus,
  output logic                   chip_sel_n,
  output logic                   out_en_n,
  output logic                   wr_en_n,
  input  wire logic [DATA_W-1:0] data_bus_i,
  output logic [DATA_W-1:0]      data_bus_o,
  output logic                   data_bus_oe
);
  typedef enum logic [1:0] {PFH_IDLE, PFH_ISSUE, PFH_WAIT} pfh_state_e;

  pfh_state_e  st_q, st_d;         // sequencer phase
  pfh_req_s    req_q, req_d;       // request being run
  logic [2:0]  idx_q, idx_d;       // cycle index within sequence
  logic [2:0]  len;                // cycles in current sequence
  logic        idm_q, idm_d;       // host mirror of id mode
  logic        byp_q, byp_d;       // host mirror of bypass mode
  logic        rv_q, rv_d;         // response pulse
  logic [7:0]  rdat_q, rdat_d;     // response byte
  pfh_cyc_s    cyc;                // current bus cycle
  logic        cyc_ready;
  logic        cyc_done;
  logic [7:0]  cyc_rd;

  // ****************************************
  // sequence table: cycle index to bus cycle
  // ****************************************
  always_comb begin
    cyc = '{wr: 1'b1, addr: 19'h00000, data: 8'h00};
    len = 3'd1;
    unique case (req_q.op)
      PFH_OP_READ: begin
        // one read; in id mode or busy the device returns codes or status
        // id reads: bits 1:0 pick the code, top bits the sector to verify
        cyc = '{wr: 1'b0, addr: req_q.addr, data: 8'h00};
      end
      PFH_OP_RESET: begin
        // reset command ends id mode and any failed sequence
        cyc.data = `PFH_CMD_RESET;
      end
      PFH_OP_BYP_PROG: begin
        // two writes only once bypass is entered
        len = 3'd2;
        cyc = (idx_q == 3'd0) ? '{wr: 1'b1, addr: 19'h00000, data: `PFH_CMD_PROG}
                              : '{wr: 1'b1, addr: req_q.addr, data: req_q.data};
      end
      PFH_OP_BYP_EXIT: begin
        len = 3'd2;
        cyc.data = (idx_q == 3'd0) ? `PFH_CMD_ID : `PFH_CMD_BYP_RST;
      end
      default: begin
        // unlocked sequences: two unlock writes then command
        unique case (req_q.op)
          PFH_OP_PROG:       len = 3'd4;
          PFH_OP_SECT_ERASE: len = 3'd6;  // sector address picks sector
          PFH_OP_CHIP_ERASE: len = 3'd6;  // whole array
          default:           len = 3'd3;
        endcase
        if ((idx_q + 3'd1 == len) && (len != 3'd3)) begin
          // last cycle: program data, or erase confirm; tested first so the
          // fourth program cycle is never mistaken for a second unlock
          if (req_q.op == PFH_OP_PROG) begin
            cyc = '{wr: 1'b1, addr: req_q.addr, data: req_q.data};
          end else if (req_q.op == PFH_OP_CHIP_ERASE) begin
            cyc = '{wr: 1'b1, addr: `PFH_UNLK_A1, data: `PFH_CMD_CHIP};
          end else begin
            cyc = '{wr: 1'b1, addr: req_q.addr, data: `PFH_CMD_SECT};
          end
        end else begin
          unique case (idx_q)
            3'd0, 3'd3: cyc = '{wr: 1'b1, addr: `PFH_UNLK_A1, data: `PFH_UNLK_D1};
            3'd1, 3'd4: cyc = '{wr: 1'b1, addr: `PFH_UNLK_A2, data: `PFH_UNLK_D2};
            default: begin
              // third cycle carries the command
              cyc.addr = `PFH_UNLK_A1;
              unique case (req_q.op)
                PFH_OP_PROG:      cyc.data = `PFH_CMD_PROG;
                PFH_OP_ID_ENTER:  cyc.data = `PFH_CMD_ID;
                PFH_OP_BYP_ENTER: cyc.data = `PFH_CMD_BYP;
                default:          cyc.data = `PFH_CMD_ERASE;
              endcase
            end
          endcase
        end
      end
    endcase
  end

  // ****************************************
  // sequencer next state
  // ****************************************
  always_comb begin
    st_d   = st_q;
    req_d  = req_q;
    idx_d  = idx_q;
    idm_d  = idm_q;
    byp_d  = byp_q;
    rv_d   = 1'b0;
    rdat_d = rdat_q;
    unique case (st_q)
      PFH_IDLE: begin
        if (req_valid) begin
          req_d = req;
          idx_d = 3'd0;
          st_d  = PFH_ISSUE;
        end
      end
      PFH_ISSUE: begin
        if (cyc_ready) st_d = PFH_WAIT;
      end
      PFH_WAIT: begin
        if (cyc_done) begin
          if (idx_q + 3'd1 < len) begin
            idx_d = idx_q + 3'd1;
            st_d  = PFH_ISSUE;
          end else begin
            st_d   = PFH_IDLE;
            rv_d   = 1'b1;
            rdat_d = cyc_rd;  // status bits while busy
            // mirror the mode the device is now in
            unique case (req_q.op)
              PFH_OP_ID_ENTER:  idm_d = 1'b1;
              PFH_OP_RESET:     idm_d = 1'b0;
              PFH_OP_BYP_ENTER: byp_d = 1'b1;
              PFH_OP_BYP_EXIT:  byp_d = 1'b0;
              default:          idm_d = idm_q;
            endcase
          end
        end
      end
      default: st_d = PFH_IDLE;
    endcase
  end

  // ****************************************
  // sequencer registers; host assumes read-array after reset
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q   <= PFH_IDLE;
      req_q  <= '0;
      idx_q  <= 3'd0;
      idm_q  <= 1'b0;
      byp_q  <= 1'b0;
      rv_q   <= 1'b0;
      rdat_q <= 8'h00;
    end else begin
      st_q   <= st_d;
      req_q  <= req_d;
      idx_q  <= idx_d;
      idm_q  <= idm_d;
      byp_q  <= byp_d;
      rv_q   <= rv_d;
      rdat_q <= rdat_d;
    end
  end

  assign req_ready = (st_q == PFH_IDLE);
  assign rsp_valid = rv_q;
  assign rsp_data  = rdat_q;
  assign id_mode   = idm_q;
  assign byp_mode  = byp_q;

  // ****************************************
  // pin cycle engine
  // ****************************************
  pfh_cycle u_cycle (
    .mclk             (mclk),
    .arst_n           (arst_n),
    .cyc              (cyc),
    .cyc_valid        (st_q == PFH_ISSUE),
    .cyc_ready        (cyc_ready),
    .cyc_done         (cyc_done),
    .rd_data          (cyc_rd),
    .byte_address_bus (byte_address_bus),
    .chip_sel_n       (chip_sel_n),
    .out_en_n         (out_en_n),
    .wr_en_n          (wr_en_n),
    .data_bus_i       (data_bus_i),
    .data_bus_o       (data_bus_o),
    .data_bus_oe      (data_bus_oe)
  );
endmodule

// File: testbench/pfh_host_chk.sv
`timescale 1ns/1ps
// ****************
// pin protocol checker for the flash host
// ****************
module pfh_host_chk (
  // clock and reset
  input wire logic        mclk,
  input wire logic        arst_n,
  // user side
  input wire logic        rsp_valid,
  // flash pins
  input wire logic [18:0] byte_address_bus,
  input wire logic        chip_sel_n,
  input wire logic        out_en_n,
  input wire logic        wr_en_n,
  input wire logic [7:0]  data_bus_o,
  input wire logic        data_bus_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // read strobe only with select and no write strobe
  property p_rd; !out_en_n |-> !chip_sel_n && wr_en_n; endproperty
  a_rd: assert property (p_rd) else $error("read strobe out of frame");
  property p_wr; !wr_en_n |-> !chip_sel_n && out_en_n; endproperty
  a_wr: assert property (p_wr) else $error("write strobe out of frame");
  // the full access time passes before the read strobe ends
  property p_acc; $fell(out_en_n) |-> !out_en_n[*7] ##1 out_en_n; endproperty
  a_acc: assert property (p_acc) else $error("read access length wrong");
  property p_wp; $fell(wr_en_n) |-> !wr_en_n[*4] ##1 wr_en_n; endproperty
  a_wp: assert property (p_wp) else $error("write pulse length wrong");
  // select released three cycles after the read strobe
  property p_rel; $rose(out_en_n) |-> !chip_sel_n[*3] ##1 chip_sel_n; endproperty
  a_rel: assert property (p_rel) else $error("select release wrong");
  property p_adr; !chip_sel_n && !$past(chip_sel_n) |-> $stable(byte_address_bus); endproperty
  a_adr: assert property (p_adr) else $error("address moved in cycle");
  // host never drives while the device may drive
  property p_wd; data_bus_oe |-> out_en_n; endproperty
  a_wd: assert property (p_wd) else $error("bus contention");
  property p_wdat; $rose(wr_en_n) |-> data_bus_oe && $stable(data_bus_o); endproperty
  a_wdat: assert property (p_wdat) else $error("write data not held");
  property p_rsp; rsp_valid |=> !rsp_valid; endproperty
  a_rsp: assert property (p_rsp) else $error("response longer than a pulse");
  c_rd: cover property ($rose(out_en_n));
  c_wr: cover property ($rose(wr_en_n));
  c_rsp: cover property (rsp_valid);
endmodule

bind pfh_host pfh_host_chk u_chk (.mclk(mclk), .arst_n(arst_n), .rsp_valid(rsp_valid),
  .byte_address_bus(byte_address_bus), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
  .wr_en_n(wr_en_n), .data_bus_o(data_bus_o), .data_bus_oe(data_bus_oe));

// File: testbench/pfh_flash_mdl.sv
`timescale 1ns/1ps
`include "pfh_map.svh"
// ****************
// behavioural flash device
// ****************
module pfh_flash_mdl #(
  parameter logic [7:0] MFR_ID  = 8'h3c, // arbitrary value
  parameter logic [7:0] DEV_ID  = 8'hc3, // arbitrary value
  parameter logic [7:0] PROT    = 8'h00,
  parameter int         BUSY_NS = 180
) (
  // flash pins
  input  wire logic [18:0] adr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [7:0]  din,
  output logic [7:0]       dout
);
  logic [7:0] mem [0:524287];
  logic [7:0] last = 8'h00;   // latched output, kept in sleep
  logic [7:0] pd = 8'hff;     // data of running operation
  int         step = 0;
  bit         idm = 0;
  bit         byp = 0;
  realtime    bz = 0;         // busy until this time
  initial foreach (mem[k]) mem[k] = 8'hff;
  function automatic logic [7:0] rd(logic [18:0] a);
    if ($realtime < bz) return {~pd[7], 7'h00};
    if (idm) begin
      if (a[1:0] == 2'b00) return MFR_ID;
      if (a[1:0] == 2'b01) return DEV_ID;
      return {7'h00, PROT[a[18:16]]};
    end
    return mem[a];
  endfunction
  // output follows address while enabled; floating bus shows the inverse
  always @* if (!ce_n && !oe_n) last = rd(adr);
  assign dout = (!ce_n && !oe_n) ? last : ~last;
  task automatic prog(logic [18:0] a, logic [7:0] d);
    if (!PROT[a[18:16]]) mem[a] = d;
    pd = d;
    bz = $realtime + BUSY_NS;
  endtask
  task automatic ers(logic [2:0] s);
    if (!PROT[s]) for (int k = 0; k < 65536; k++) mem[{s, k[15:0]}] = 8'hff;
    pd = 8'hff;
    bz = $realtime + BUSY_NS;
  endtask
  // commands latched at the write strobe rise; ignored while busy
  always @(posedge we_n) if (!ce_n && oe_n && $realtime >= bz) begin
    if (byp) begin
      if (step == 1) prog(adr, din);
      if (step == 2) byp = (din != `PFH_CMD_BYP_RST);
      step = (step != 0) ? 0 : (din == `PFH_CMD_PROG) ? 1 : (din == `PFH_CMD_ID) ? 2 : 0;
    end else case (step)
      0: begin
        if (din == `PFH_CMD_RESET) idm = 0;
        step = (adr == `PFH_UNLK_A1 && din == `PFH_UNLK_D1) ? 1 : 0;
      end
      1, 4: step = (adr == `PFH_UNLK_A2 && din == `PFH_UNLK_D2) ? step + 1 : 0;
      2: begin
        step = 0;
        if (adr == `PFH_UNLK_A1 && din == `PFH_CMD_PROG) step = 3;
        if (adr == `PFH_UNLK_A1 && din == `PFH_CMD_ERASE) step = 6;
        if (adr == `PFH_UNLK_A1 && din == `PFH_CMD_ID) idm = 1;
        if (adr == `PFH_UNLK_A1 && din == `PFH_CMD_BYP) byp = 1;
      end
      3: begin
        prog(adr, din);
        step = 0;
      end
      5: begin
        if (din == `PFH_CMD_CHIP) for (int s = 0; s < 8; s++) ers(s[2:0]);
        if (din == `PFH_CMD_SECT) ers(adr[18:16]);
        step = 0;
      end
      6: step = (adr == `PFH_UNLK_A1 && din == `PFH_UNLK_D1) ? 4 : 0;
      default: step = 0;
    endcase
  end
endmodule

// File: testbench/pfh_host_tb.sv
`timescale 1ns/1ps
// ****************
// flash host testbench
// ****************
module pfh_host_tb;
  import pfh_pkg::*;
  localparam logic [7:0] MFR = 8'h3c; // arbitrary value
  localparam logic [7:0] DEV = 8'hc3; // arbitrary value
  logic        mclk = 0, arst_n = 0, req_valid = 0;
  pfh_req_s    req = '0;
  logic        req_ready, rsp_valid, id_mode, byp_mode, chip_sel_n, out_en_n, wr_en_n;
  logic        data_bus_oe;
  logic [7:0]  rsp_data, data_bus_i, data_bus_o, bus_w, d;
  logic [18:0] byte_address_bus, a;
  logic [31:0] r;
  logic [8:0]  note;      // oldest expectation, owned by the watcher
  logic [8:0]  exp_q [$]; // bit 8 marks a byte worth comparing
  int          err_total = 0, checked = 0;
  initial forever #5 mclk = ~mclk;
  assign bus_w = data_bus_oe ? data_bus_o : data_bus_i;
  pfh_host dut (.mclk, .arst_n, .req, .req_valid, .req_ready, .rsp_valid, .rsp_data, .id_mode,
    .byp_mode, .byte_address_bus, .chip_sel_n, .out_en_n, .wr_en_n, .data_bus_i, .data_bus_o,
    .data_bus_oe);
  // sector 2 protected beforehand
  pfh_flash_mdl #(.MFR_ID(MFR), .DEV_ID(DEV), .PROT(8'h04)) u_flash (.adr(byte_address_bus),
    .ce_n(chip_sel_n), .oe_n(out_en_n), .we_n(wr_en_n), .din(bus_w), .dout(data_bus_i));
  task automatic check(logic [7:0] got, logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // response watcher takes the oldest note
  always @(negedge mclk) if (rsp_valid === 1'b1 && exp_q.size() > 0) begin
    note = exp_q.pop_front();
    if (note[8]) check(rsp_data, note[7:0]);
  end
  // one request, held until taken, then wait for its answer
  task automatic op(pfh_op_e o, logic [18:0] ad, logic [7:0] dd, logic [8:0] e);
    int n;
    n = 0;
    @(posedge mclk); #1;
    while (req_ready !== 1'b1) begin @(posedge mclk); #1; end
    req = '{o, ad, dd};
    req_valid = 1;
    exp_q.push_back(e);
    @(posedge mclk); #1;
    req_valid = 0;
    while (rsp_valid !== 1'b1 && n < 200) begin @(posedge mclk); #1; n++; end
    if (n >= 200) begin
      err_total++;
      $display("Error at %0t: no response", $time);
    end
  endtask
  task automatic rd(logic [18:0] ad, logic [7:0] e); op(PFH_OP_READ, ad, 8'h00, {1'b1, e}); endtask
  task automatic wr(pfh_op_e o, logic [18:0] ad); op(o, ad, 8'h00, 9'h000); endtask
  // program, read status while busy, then read back
  task automatic pchk(logic [18:0] ad, logic [7:0] dd, logic [7:0] e);
    op(PFH_OP_PROG, ad, dd, 9'h000);
    rd(ad, {~dd[7], 7'h00});
    rd(ad, e);
  endtask
  initial begin
    #200000;
    err_total++;
    print_verdict;
  end
  initial begin
    void'($urandom(32'hb6a3));
    repeat (2) @(posedge mclk);
    #1 arst_n = 1;
    rd(19'h01234, 8'hff);
    pchk(19'h12345, 8'h5a, 8'h5a);
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      a = {3'd3, r[15:0]};
      d = r[23:16];
      pchk(a, d, d);
    end
    pchk(19'h20010, 8'h33, 8'hff);
    wr(PFH_OP_BYP_ENTER, 19'h0);
    check({7'h00, byp_mode}, 8'h01);
    // the host does not poll; a status read lets the busy time pass before the next write
    op(PFH_OP_BYP_PROG, 19'h40001, 8'h11, 9'h000);
    rd(19'h40001, 8'h80);
    op(PFH_OP_BYP_PROG, 19'h40002, 8'h22, 9'h000);
    rd(19'h40002, 8'h80);
    wr(PFH_OP_BYP_EXIT, 19'h0);
    check({7'h00, byp_mode}, 8'h00);
    rd(19'h40001, 8'h11);
    rd(19'h40002, 8'h22);
    wr(PFH_OP_ID_ENTER, 19'h0);
    check({7'h00, id_mode}, 8'h01);
    rd(19'h00000, MFR);
    rd(19'h00001, DEV);
    rd(19'h20002, 8'h01);
    rd(19'h50002, 8'h00);
    wr(PFH_OP_RESET, 19'h0);
    check({7'h00, id_mode}, 8'h00);
    rd(19'h40001, 8'h11);
    wr(PFH_OP_SECT_ERASE, 19'h40000);
    rd(19'h40002, 8'h00);
    rd(19'h40002, 8'hff);
    rd(19'h12345, 8'h5a);
    wr(PFH_OP_CHIP_ERASE, 19'h0);
    rd(19'h12345, 8'h00);
    rd(19'h12345, 8'hff);
    print_verdict;
  end
endmodule
